// File: rtl/hts_pkg.sv
package hts_pkg;
	// clock and dwell timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int DWELL_DEF_NS = 5000;
	localparam int DWELL_MIN_NS = 1;
	localparam longint DWELL_MAX_NS = 10_000_000_000;
	localparam logic [31:0] DWELL_DEF_CYC = 32'((DWELL_DEF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [31:0] DWELL_MIN_CYC = 32'((DWELL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [31:0] DWELL_MAX_CYC = 32'(DWELL_MAX_NS / CLK_PERIOD_NS);
	// table size limits
	localparam int TAB_MIN = 2;
	localparam int TAB_MAX = 256;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FDWELL = 8'h04;
	localparam logic [7:0] OFS_ADWELL = 8'h08;
	localparam logic [7:0] OFS_CARRIER = 8'h0C;
	localparam logic [7:0] OFS_FMARK = 8'h10;
	localparam logic [7:0] OFS_AMARK = 8'h14;
	localparam logic [7:0] OFS_LOAD = 8'h18;
	localparam logic [7:0] OFS_DATA = 8'h1C;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	// control fields
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_FVAR_BIT = 1;
	localparam int CTRL_AVAR_BIT = 2;
	localparam logic [31:0] CTRL_MASK = 32'h0000_0007;
	// load command fields
	localparam int LOAD_LEN_MSB = 15;
	localparam int LOAD_AMP_BIT = 16;
	localparam int LOAD_VAR_BIT = 17;
	localparam logic [31:0] LOAD_MASK = 32'h0003_FFFF;
	// status fields
	localparam int STAT_VALID_BIT = 0;
	localparam int STAT_LOADING_BIT = 1;
	localparam int STAT_ERR_BIT = 2;
	localparam int STAT_RUN_BIT = 3;
	localparam int STAT_AMP_BIT = 4;
	localparam int STAT_VAR_BIT = 5;
	localparam int STAT_IDX_LSB = 16;
	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0006;
	localparam logic [31:0] MARK_RST = 32'h0000_0001;
	localparam logic [31:0] CARRIER_RST = 32'h0000_0000;
	localparam logic [31:0] LOAD_RST = 32'h0000_0000;
	// sequencer states
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_PUSH, SEQ_DWELL, SEQ_FINISH} hts_seq_t;
endpackage

// File: rtl/hts_pipe_buf.sv
`timescale 1ns/1ns
module hts_pipe_buf #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] slot [DEPTH];
	logic [DEPTH-1:0] vld;
	logic [WIDTH-1:0] next_slot [DEPTH];
	logic [DEPTH-1:0] next_vld;
	logic placed;

	// head slot drives the output directly
	assign out_valid = vld[0];
	assign out_data = slot[0];
	assign in_ready = !vld[DEPTH-1];

	// shift on pop, then place into first free slot
	always_comb begin
		placed = 1'b0;
		next_slot = slot;
		next_vld = vld;
		if (vld[0] && out_ready) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				next_slot[i] = slot[i+1];
				next_vld[i] = vld[i+1];
			end
			next_vld[DEPTH-1] = 1'b0;
		end
		if (in_valid && in_ready) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (!placed && !next_vld[i]) begin
					next_slot[i] = in_data;
					next_vld[i] = 1'b1;
					placed = 1'b1;
				end
			end
		end
	end

	// register slots
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vld <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				slot[i] <= '0;
			end
		end else begin
			vld <= next_vld;
			slot <= next_slot;
		end
	end
endmodule

// File: rtl/hts_hop_table_sequencer.sv
// Overview of operation
// - variable table entries are value then dwell; each step uses its own dwell
// - variable table accepts and stores two to 256 pairs
// - variable table in variable dwell mode means fixed dwell setting is ignored; in fixed mode the fixed dwell is used
// - step never ends before the current output cycle finishes
// - sync pulse when the programmed index is reached; index defaults to one
// - marker index reads back as stored, limited to one..table depth
// - each function has fixed or variable dwell mode; variable after reset
// - dwell mode reads back as fixed or variable
// - fixed mode uses one dwell for all steps, one ns to ten s, default 5 us
// - dwell setting reads back as the stored value
// - fixed table accepts two to 256 values with no dwell data
// - each hop moves to the next entry and outputs its value
// - load header gives the byte length of the block to accept
// - hop timing is internal, rate from dwell, order from table
// - one carrier frequency setting shared by all functions
`timescale 1ns/1ns
module hts_hop_table_sequencer #(
	parameter int TAB_DEPTH = hts_pkg::TAB_MAX,
	parameter logic [31:0] MAX_DWELL_CYC = hts_pkg::DWELL_MAX_CYC
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// synthesis datapath
	input wire logic cycle_end,
	output logic hop_valid,
	input wire logic hop_ready,
	output logic [63:0] hop_value,
	output logic hop_function,
	output logic [31:0] carrier_frequency,
	output logic sync_marker
);
	localparam int IW = $clog2(TAB_DEPTH);
	localparam int LW = IW + 1;

	// table storage
	logic [63:0] tab_val [TAB_DEPTH];
	logic [31:0] tab_dw [TAB_DEPTH];

	// register state
	logic wr_pend, next_wr_pend;
	logic [7:0] wr_addr, next_wr_addr;
	logic [31:0] rdata, next_rdata;
	logic [31:0] ctrl, next_ctrl;
	logic [31:0] fdwell, next_fdwell;
	logic [31:0] adwell, next_adwell;
	logic [31:0] carrier, next_carrier;
	logic [LW-1:0] fmark, next_fmark;
	logic [LW-1:0] amark, next_amark;
	logic [31:0] load, next_load;
	logic loading, next_loading;
	logic load_err, next_load_err;
	logic tab_valid, next_tab_valid;
	logic tab_amp, next_tab_amp;
	logic tab_var, next_tab_var;
	logic [LW-1:0] tab_len, next_tab_len;
	logic [LW-1:0] ld_len, next_ld_len;
	logic [12:0] wcnt, next_wcnt;
	logic [31:0] lo_word, next_lo_word;
	// table write strobes
	logic val_we, dw_we;
	logic [IW-1:0] waddr;
	logic [63:0] wdata;
	// load decode helpers
	logic [15:0] req_bytes;
	logic req_var;
	logic [15:0] req_len;
	logic [12:0] req_words;
	logic [12:0] tot_words;
	logic [11:0] dbl_idx;
	// sequencer state
	hts_pkg::hts_seq_t seq, next_seq;
	logic [IW-1:0] idx, next_idx;
	logic [31:0] dcnt, next_dcnt;
	logic next_sync, next_func;
	logic [31:0] next_carrier_out;
	logic use_var, buf_ready, push;
	logic [LW-1:0] mark_sel;

	// keep a dwell setting inside one cycle and the ten second ceiling
	function automatic logic [31:0] clamp_dwell(input logic [31:0] v);
		return (v < hts_pkg::DWELL_MIN_CYC) ? hts_pkg::DWELL_MIN_CYC
			: ((v > MAX_DWELL_CYC) ? MAX_DWELL_CYC : v);
	endfunction

	// marker index limited to one..table depth
	function automatic logic [LW-1:0] clamp_mark(input logic [31:0] v);
		return (v == 32'h0000_0000) ? LW'(1)
			: ((v > 32'(TAB_DEPTH)) ? LW'(TAB_DEPTH) : v[LW-1:0]);
	endfunction

	// decode a load header
	assign req_bytes = hwdata[hts_pkg::LOAD_LEN_MSB:0];
	assign req_var = hwdata[hts_pkg::LOAD_VAR_BIT];
	assign req_len = req_var ? (req_bytes >> 4) : (req_bytes >> 3);
	assign req_words = (req_bytes[1:0] == 2'b00) ? 13'(req_bytes >> 2) : 13'h1FFF; // partial words never match
	assign tot_words = load[hts_pkg::LOAD_VAR_BIT] ? 13'({ld_len, 2'b00}) : 13'({ld_len, 1'b0});
	assign dbl_idx = wcnt[12:1];

	// bus slave, settings and table loading
	always_comb begin
		next_wr_pend = 1'b0;
		next_wr_addr = wr_addr;
		next_rdata = rdata;
		next_ctrl = ctrl;
		next_fdwell = fdwell;
		next_adwell = adwell;
		next_carrier = carrier;
		next_fmark = fmark;
		next_amark = amark;
		next_load = load;
		next_loading = loading;
		next_load_err = load_err;
		next_tab_valid = tab_valid;
		next_tab_amp = tab_amp;
		next_tab_var = tab_var;
		next_tab_len = tab_len;
		next_ld_len = ld_len;
		next_wcnt = wcnt;
		next_lo_word = lo_word;
		val_we = 1'b0;
		dw_we = 1'b0;
		waddr = '0;
		wdata = 64'h0000_0000_0000_0000;
		// address phase: latch writes, fetch read data
		if (hsel && htrans[1] && hready) begin
			next_wr_pend = hwrite;
			next_wr_addr = haddr[7:0];
			if (!hwrite) begin
				case (haddr[7:0])
					hts_pkg::OFS_CTRL: next_rdata = ctrl;
					hts_pkg::OFS_FDWELL: next_rdata = fdwell;
					hts_pkg::OFS_ADWELL: next_rdata = adwell;
					hts_pkg::OFS_CARRIER: next_rdata = carrier;
					hts_pkg::OFS_FMARK: next_rdata = 32'(fmark);
					hts_pkg::OFS_AMARK: next_rdata = 32'(amark);
					hts_pkg::OFS_LOAD: next_rdata = load;
					hts_pkg::OFS_STATUS: begin
						next_rdata = 32'h0000_0000;
						next_rdata[hts_pkg::STAT_VALID_BIT] = tab_valid;
						next_rdata[hts_pkg::STAT_LOADING_BIT] = loading;
						next_rdata[hts_pkg::STAT_ERR_BIT] = load_err;
						next_rdata[hts_pkg::STAT_RUN_BIT] = (seq != hts_pkg::SEQ_IDLE);
						next_rdata[hts_pkg::STAT_AMP_BIT] = tab_amp;
						next_rdata[hts_pkg::STAT_VAR_BIT] = use_var;
						next_rdata[hts_pkg::STAT_IDX_LSB +: IW] = idx;
					end
					default: next_rdata = 32'h0000_0000;
				endcase
			end
		end
		// data phase: apply a pending write
		if (wr_pend) begin
			case (wr_addr)
				hts_pkg::OFS_CTRL: next_ctrl = hwdata & hts_pkg::CTRL_MASK;
				hts_pkg::OFS_FDWELL: next_fdwell = clamp_dwell(hwdata);
				hts_pkg::OFS_ADWELL: next_adwell = clamp_dwell(hwdata);
				hts_pkg::OFS_CARRIER: next_carrier = hwdata;
				hts_pkg::OFS_FMARK: next_fmark = clamp_mark(hwdata);
				hts_pkg::OFS_AMARK: next_amark = clamp_mark(hwdata);
				hts_pkg::OFS_LOAD: begin
					// header byte length sets how many words to accept
					next_load = hwdata & hts_pkg::LOAD_MASK;
					next_tab_valid = 1'b0;
					next_wcnt = '0;
					next_ld_len = LW'(req_len);
					if (req_len >= 16'(hts_pkg::TAB_MIN) && req_len <= 16'(TAB_DEPTH)
						&& req_words == (req_var ? 13'({req_len, 2'b00}) : 13'({req_len, 1'b0}))) begin
						next_loading = 1'b1;
						next_load_err = 1'b0;
					end else begin
						next_loading = 1'b0;
						next_load_err = 1'b1;
					end
				end
				hts_pkg::OFS_DATA: begin
					if (loading) begin
						next_wcnt = wcnt + 13'd1;
						if (!wcnt[0]) begin
							next_lo_word = hwdata;
						end else if (load[hts_pkg::LOAD_VAR_BIT]) begin
							// even double is the value, odd double the dwell
							waddr = dbl_idx[IW:1];
							wdata = dbl_idx[0] ? {hwdata, clamp_dwell(lo_word)} : {hwdata, lo_word};
							val_we = !dbl_idx[0];
							dw_we = dbl_idx[0];
						end else begin
							waddr = dbl_idx[IW-1:0];
							wdata = {hwdata, lo_word};
							val_we = 1'b1;
						end
						if (next_wcnt == tot_words) begin
							next_loading = 1'b0;
							next_tab_valid = 1'b1;
							next_tab_len = ld_len;
							next_tab_amp = load[hts_pkg::LOAD_AMP_BIT];
							next_tab_var = load[hts_pkg::LOAD_VAR_BIT];
						end
					end
				end
				default: next_wr_addr = wr_addr; // unmapped writes ignored
			endcase
		end
	end

	// register bus and settings
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			rdata <= 32'h0000_0000;
			ctrl <= hts_pkg::CTRL_RST;
			fdwell <= hts_pkg::DWELL_DEF_CYC;
			adwell <= hts_pkg::DWELL_DEF_CYC;
			carrier <= hts_pkg::CARRIER_RST;
			fmark <= LW'(hts_pkg::MARK_RST);
			amark <= LW'(hts_pkg::MARK_RST);
			load <= hts_pkg::LOAD_RST;
			loading <= 1'b0;
			load_err <= 1'b0;
			tab_valid <= 1'b0;
			tab_amp <= 1'b0;
			tab_var <= 1'b0;
			tab_len <= '0;
			ld_len <= '0;
			wcnt <= '0;
			lo_word <= 32'h0000_0000;
		end else begin
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			rdata <= next_rdata;
			ctrl <= next_ctrl;
			fdwell <= next_fdwell;
			adwell <= next_adwell;
			carrier <= next_carrier;
			fmark <= next_fmark;
			amark <= next_amark;
			load <= next_load;
			loading <= next_loading;
			load_err <= next_load_err;
			tab_valid <= next_tab_valid;
			tab_amp <= next_tab_amp;
			tab_var <= next_tab_var;
			tab_len <= next_tab_len;
			ld_len <= next_ld_len;
			wcnt <= next_wcnt;
			lo_word <= next_lo_word;
		end
	end

	// table storage writes
	always_ff @(posedge hclk) begin
		if (val_we) begin
			tab_val[waddr] <= wdata;
		end
		if (dw_we) begin
			tab_dw[waddr] <= wdata[31:0];
		end
	end

	// per-entry dwell only when the mode is variable and the table carries dwells
	assign use_var = tab_amp ? (ctrl[hts_pkg::CTRL_AVAR_BIT] && tab_var)
		: (ctrl[hts_pkg::CTRL_FVAR_BIT] && tab_var);
	assign mark_sel = tab_amp ? amark : fmark;
	assign push = (seq == hts_pkg::SEQ_PUSH) && buf_ready;

	// hop sequencer
	always_comb begin
		next_seq = seq;
		next_idx = idx;
		next_dcnt = dcnt;
		next_sync = 1'b0;
		next_func = tab_amp;
		next_carrier_out = carrier;
		case (seq)
			hts_pkg::SEQ_IDLE: begin
				next_idx = '0;
				if (ctrl[hts_pkg::CTRL_RUN_BIT] && tab_valid) begin
					next_seq = hts_pkg::SEQ_PUSH;
				end
			end
			hts_pkg::SEQ_PUSH: begin
				if (buf_ready) begin
					next_sync = (LW'(idx) + LW'(1)) == mark_sel;
					next_dcnt = use_var ? tab_dw[idx] : (tab_amp ? adwell : fdwell);
					next_seq = hts_pkg::SEQ_DWELL;
				end
			end
			hts_pkg::SEQ_DWELL: begin
				next_dcnt = dcnt - 32'd1;
				if (dcnt <= 32'd1) begin
					next_seq = hts_pkg::SEQ_FINISH;
				end
			end
			hts_pkg::SEQ_FINISH: begin
				// hold the step until the running output cycle completes
				if (cycle_end) begin
					next_seq = hts_pkg::SEQ_PUSH;
					if (LW'(idx) + LW'(1) >= tab_len) begin
						next_idx = '0;
					end else begin
						next_idx = idx + IW'(1);
					end
				end
			end
			default: next_seq = hts_pkg::SEQ_IDLE;
		endcase
		if (!ctrl[hts_pkg::CTRL_RUN_BIT] || !tab_valid) begin
			next_seq = hts_pkg::SEQ_IDLE;
		end
	end

	// sequencer registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seq <= hts_pkg::SEQ_IDLE;
			idx <= '0;
			dcnt <= 32'h0000_0000;
			sync_marker <= 1'b0;
			hop_function <= 1'b0;
			carrier_frequency <= hts_pkg::CARRIER_RST;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			seq <= next_seq;
			idx <= next_idx;
			dcnt <= next_dcnt;
			sync_marker <= next_sync;
			hop_function <= next_func;
			carrier_frequency <= next_carrier_out;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	assign hrdata = rdata;

	// two-entry buffer toward the synthesis datapath
	hts_pipe_buf #(
		.WIDTH(64),
		.DEPTH(2)
	) u_buf (
		.hclk(hclk),
		.hresetn(hresetn),
		.in_valid(push),
		.in_ready(buf_ready),
		.in_data(tab_val[idx]),
		.out_valid(hop_valid),
		.out_ready(hop_ready),
		.out_data(hop_value)
	);
endmodule

// File: verification/hts_hop_table_sequencer_props.sv
`timescale 1ns/1ns
module hts_hop_table_sequencer_props (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus side
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// stream side
	input wire logic hop_valid,
	input wire logic hop_ready,
	input wire logic [63:0] hop_value,
	input wire logic [31:0] carrier_frequency,
	input wire logic sync_marker
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// address phases taken by the slave
	sequence rd_taken(logic [7:0] a);
		hsel && htrans[1] && hready && !hwrite && haddr[7:0] == a;
	endsequence
	sequence wr_taken(logic [7:0] a);
		hsel && htrans[1] && hready && hwrite && haddr[7:0] == a;
	endsequence
	// carrier write lands on the output port
	property carrier_copy;
		logic [31:0] d;
		wr_taken(hts_pkg::OFS_CARRIER) ##1 (1, d = hwdata) |-> ##[1:2] carrier_frequency == d;
	endproperty
	a_ready_always: assert property ($past(hresetn) |-> hreadyout)
		else $error("slave not ready");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");
	a_hop_held: assert property (hop_valid && !hop_ready |=> hop_valid && $stable(hop_value))
		else $error("hop word dropped or changed while stalled");
	a_sync_single: assert property (sync_marker |=> !sync_marker)
		else $error("sync pulse longer than one cycle");
	a_sync_with_hop: assert property (sync_marker |-> ##[0:1] hop_valid)
		else $error("sync pulse without a hop word");
	a_carrier_follow: assert property (carrier_copy)
		else $error("carrier output did not follow write");
	a_data_reads_zero: assert property (rd_taken(hts_pkg::OFS_DATA) |=> hrdata == 32'h0000_0000)
		else $error("data port read not zero");
	a_unmapped_zero: assert property (rd_taken(8'h40) |=> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
endmodule
bind hts_hop_table_sequencer hts_hop_table_sequencer_props chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .hreadyout, .hresp, .hrdata, .hop_valid, .hop_ready, .hop_value, .carrier_frequency,
	.sync_marker);

// File: verification/hts_sink_model.sv
`timescale 1ns/1ns
module hts_sink_model (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// hop stream
	input wire logic hop_valid,
	output logic hop_ready,
	input wire logic [63:0] hop_value,
	// pacing from the bench
	input wire logic stall,
	input wire logic ce_en,
	// output period boundary
	output logic cycle_end
);
	logic [4:0] cnt;
	logic [63:0] rx[$];
	// pace counter, ready pattern, period pulses and capture
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 5'h00;
			hop_ready <= 1'b0;
			cycle_end <= 1'b0;
		end else begin
			cnt <= cnt + 5'h01;
			hop_ready <= !stall || cnt == 5'h00; // stalled: ready one cycle in 32
			cycle_end <= ce_en && cnt[1:0] == 2'h3; // a period ends every four cycles
			if (hop_valid && hop_ready)
				rx.push_back(hop_value); // accepted words in arrival order
		end
	end
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ns
module testbench;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic stall = 1'b0;
	logic ce_en = 1'b1;
	logic hreadyout, hresp, hop_valid, hop_ready, hop_function, sync_marker, cycle_end;
	logic [31:0] hrdata, carrier_frequency, q;
	logic [63:0] hop_value;
	int mismatches = 0;
	int n_checks = 0;
	int nsync = 0;
	int n0;
	logic [7:0] ofs[10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h40};
	logic [31:0] rst[10] = '{hts_pkg::CTRL_RST, hts_pkg::DWELL_DEF_CYC, hts_pkg::DWELL_DEF_CYC,
		hts_pkg::CARRIER_RST, hts_pkg::MARK_RST, hts_pkg::MARK_RST, hts_pkg::LOAD_RST, 32'h0, 32'h0, 32'h0};
	logic [31:0] bad[6] = '{32'h0000_0008, 32'h0000_0808, 32'h0002_0010, 32'h0002_1010, 32'h0000_000C,
		32'h0000_0012};
	logic [31:0] vw[8] = '{32'h0000_00A0, 32'h0, 32'h3, 32'hFFFF_FFFF, 32'h0000_00A4, 32'h0, 32'h3, 32'hFFFF_FFFF};
	// clock
	always #10 hclk = ~hclk;
	// count marker pulses
	always @(posedge hclk)
		if (sync_marker === 1'b1)
			nsync++;
	hts_hop_table_sequencer #(.MAX_DWELL_CYC(32'h0000_03E8)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cycle_end, .hop_valid,
		.hop_ready, .hop_value, .hop_function, .carrier_frequency, .sync_marker);
	hts_sink_model sink (.hclk, .hresetn, .hop_valid, .hop_ready, .hop_value, .stall, .ce_en, .cycle_end);
	task end_of_test;
		if (mismatches == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [63:0] s, input logic [63:0] e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// bounded wait for hready at a rising edge
	task wait_rdy;
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (hreadyout !== 1'b1) begin
			chk("bus ready", 64'(hreadyout), 64'h1);
			end_of_test();
		end
	endtask
	// single word transfer: address phase, then data phase
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e, input string nm);
		xfer(1'b0, a, 32'h0000_0000);
		chk(nm, 64'(q), 64'(e));
	endtask
	task wait_rx(input int n);
		int k;
		k = 0;
		while (sink.rx.size() < n && k < 20000) begin
			@(posedge hclk);
			k++;
		end
		if (sink.rx.size() < n) begin
			chk("hop count", 64'(sink.rx.size()), 64'(n));
			end_of_test();
		end
	endtask
	// main sequence
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		cyc(2);
		foreach (ofs[i])
			rc(ofs[i], rst[i], "reset value");
		wr(hts_pkg::OFS_FDWELL, 32'h0000_0000);
		rc(hts_pkg::OFS_FDWELL, 32'h0000_0001, "dwell min");
		wr(hts_pkg::OFS_ADWELL, 32'h0000_07D0);
		rc(hts_pkg::OFS_ADWELL, 32'h0000_03E8, "dwell max");
		wr(hts_pkg::OFS_FMARK, 32'h0000_0000);
		rc(hts_pkg::OFS_FMARK, 32'h0000_0001, "mark min");
		wr(hts_pkg::OFS_FMARK, 32'h0000_0002); // marker set before the table
		rc(hts_pkg::OFS_FMARK, 32'h0000_0002, "mark");
		wr(hts_pkg::OFS_FDWELL, 32'h0000_0004); // short dwell keeps the table total small
		wr(hts_pkg::OFS_CARRIER, 32'h1234_5678);
		rc(hts_pkg::OFS_CARRIER, 32'h1234_5678, "carrier");
		chk("carrier out", 64'(carrier_frequency), 64'h1234_5678);
		// byte counts that fit no legal table
		foreach (bad[i]) begin
			wr(hts_pkg::OFS_LOAD, bad[i]);
			rc(hts_pkg::OFS_STATUS, 32'h0000_0004, "load error");
		end
		// largest fixed frequency table, value equals index
		wr(hts_pkg::OFS_LOAD, 32'h0000_0800);
		for (int i = 0; i < 256; i++) begin
			wr(hts_pkg::OFS_DATA, 32'(i));
			wr(hts_pkg::OFS_DATA, 32'h0000_0000);
		end
		xfer(1'b0, hts_pkg::OFS_STATUS, 32'h0000_0000);
		chk("table valid", 64'(q[0]), 64'h1);
		stall <= 1'b1;
		nsync = 0;
		wr(hts_pkg::OFS_CTRL, 32'h0000_0005);
		rc(hts_pkg::OFS_CTRL, 32'h0000_0005, "mode");
		wait_rx(260);
		for (int k = 0; k < 260; k++)
			chk("hop order", sink.rx[k], 64'(k % 256));
		chk("sync count", 64'(nsync), 64'h2);
		chk("function", 64'(hop_function), 64'h0);
		// variable amplitude table, long fixed dwell left in place
		wr(hts_pkg::OFS_CTRL, 32'h0000_0004);
		stall <= 1'b0;
		wr(hts_pkg::OFS_LOAD, 32'h0003_0020);
		for (int i = 0; i < 8; i++) begin
			if (i == 7)
				rc(hts_pkg::OFS_STATUS, 32'h0000_0002, "valid early");
			wr(hts_pkg::OFS_DATA, vw[i]);
		end
		sink.rx.delete();
		wr(hts_pkg::OFS_CTRL, 32'h0000_0005);
		cyc(200);
		chk("own dwell", 64'(sink.rx.size() > 10), 64'h1);
		for (int k = 0; k < 4; k++)
			chk("var order", sink.rx[k], (k % 2) ? 64'h0000_0000_0000_00A4 : 64'h0000_0000_0000_00A0);
		chk("function", 64'(hop_function), 64'h1);
		// withheld period end holds the step
		ce_en <= 1'b0;
		cyc(10);
		n0 = sink.rx.size();
		cyc(60);
		chk("held step", 64'(sink.rx.size()), 64'(n0));
		ce_en <= 1'b1;
		cyc(20);
		chk("resumed", 64'(sink.rx.size() > n0), 64'h1);
		// fixed amplitude mode over a variable table: one common dwell of 1000 cycles
		wr(hts_pkg::OFS_CTRL, 32'h0000_0000);
		cyc(4);
		sink.rx.delete();
		nsync = 0;
		wr(hts_pkg::OFS_CTRL, 32'h0000_0001);
		cyc(900);
		chk("fixed dwell held", 64'(sink.rx.size()), 64'h1);
		rc(hts_pkg::OFS_STATUS, 32'h0000_0019, "fixed status");
		cyc(200);
		chk("fixed dwell next", 64'(sink.rx.size()), 64'h2);
		chk("amp marker", 64'(nsync), 64'h1);
		end_of_test();
	end
endmodule
